// [design/cocr_consts.vh]
// Constants for the charger option three control register block.
// Assumes byte-wide register access from an external serial engine.
`ifndef COCR_CONSTS_VH
`define COCR_CONSTS_VH

// Byte addresses of the two halves of the register.
`define COCR_ADDR_LOW           8'h34
`define COCR_ADDR_HIGH          8'h35
`define COCR_RESET_VALUE        16'h0030
`define COCR_READ_IDLE          8'h00
`define COCR_CELL_SELECT_RESET  2'h0
// First register bit carried by the high byte lane.
`define COCR_HIGH_BYTE_BASE     8

// High byte field positions within the 16-bit register.
`define COCR_BIT_HIZ            15
`define COCR_BIT_RESTORE        14
`define COCR_BIT_REMEASURE      13
`define COCR_BIT_REVERSE        12
`define COCR_BIT_OPTIMIZER      11
// Low byte field positions.
`define COCR_BIT_CONS_SUPP      6
`define COCR_BIT_PIN_SELECT     5
`define COCR_CLAMP_MSB          4
`define COCR_CLAMP_LSB          3
`define COCR_BIT_RANGE_LOW      2
`define COCR_BIT_BATT_OFF_IDLE  1
`define COCR_BIT_PMON_SELECT    0

// Clamp field encodings and the clamp level in amperes.
`define COCR_CLAMP_6A_CODE      2'h0
`define COCR_CLAMP_10A_CODE     2'h1
`define COCR_CLAMP_15A_CODE     2'h2
`define COCR_CLAMP_OFF_CODE     2'h3
`define COCR_CLAMP_6A           5'h06
`define COCR_CLAMP_10A          5'h0A
`define COCR_CLAMP_15A          5'h0F
`define COCR_CLAMP_NONE         5'h00

// Minimum system voltage single-cell default, in millivolts (3584 mV).
`define COCR_MINIMUM_SYSTEM_VOLTAGE_DEFAULT   16'h0E00

// Remeasure sequencer states.
`define COCR_ST_IDLE            1'h0
`define COCR_ST_MEASURE         1'h1

`endif

// [design/cocr_reset_sync.v]
// Reset release synchroniser for the control register block.
// Assumes an asynchronous active-low reset that may be released at any time.
`timescale 1ns/100ps
`default_nettype none

module cocr_reset_sync (
    // Clock and raw reset
    input  wire core_clk,
    input  wire reset_n,
    // Synchronised reset
    output wire sync_reset_n
);

    reg [1:0] stage;

    // Assertion is immediate, release waits two edges to avoid metastability.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage <= 2'h0;
        end else begin
            stage <= {stage[0], 1'b1};
        end
    end

    assign sync_reset_n = stage[1];

endmodule

`default_nettype wire

// [design/cocr_control_reg.v]
// Charger option three control register with its control side effects.
// Assumes byte accesses arrive already decoded by the serial engine, one
// access per strobe, and that the converter side answers remeasure requests.
//
// Summary of operation
// - At power-on the register holds 0030h, so every high-byte control is zero.
// - The high-impedance bit puts the device in minimal-current state, keeping the regulator on from the battery when input is above lockout.
// - Writing one to the restore bit returns all registers to defaults except the input voltage limit threshold.
// - A restore loads the 3.584V single-cell minimum system voltage and the charge voltage chosen by the cell-count pin.
// - The restore bit clears itself after the restore, so a later read shows zero.
// - Writing one to the remeasure bit pauses the converter until the measurement ends, then clears the bit and restarts.
// - Reverse supply runs only while its enable bit is one, the pin-function select is one and the external enable pin is high.
// - The input current optimizer runs only while its enable bit is one, zero at power-on.
// - The pin-function select routes the shared pin to supplement mode when zero or reverse supply when one, one at power-on.
// - The clamp field selects 6A, 10A or 15A, 15A at power-on, and 11b turns the clamp off.
// - The range bit selects the high reverse output range when zero and the low range when one.
`timescale 1ns/100ps
`default_nettype none
`include "cocr_consts.vh"

module cocr_control_reg (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // Byte register access
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr_en,
    input  wire [7:0]  reg_wr_data,
    input  wire        reg_rd_en,
    output reg  [7:0]  reg_rd_data,
    output reg         reg_rd_hit,
    // Device pins and converter status
    input  wire        shared_pin_level,
    input  wire        input_above_uvlo,
    input  wire [1:0]  cell_count_pin,
    input  wire        remeasure_done,
    // Restore-defaults outputs
    output reg         restore_defaults_pulse,
    output reg  [15:0] minimum_system_voltage_load,
    output reg  [1:0]  charge_voltage_default_select,
    // Remeasure outputs
    output reg         remeasure_start_pulse,
    output wire        converter_pause,
    output reg         converter_restart_pulse,
    // Operating controls
    output wire        high_impedance_state_enable,
    output wire        internal_regulator_output_on,
    output wire        system_from_battery,
    output wire        battery_switch_off_in_idle,
    output wire        reverse_supply_active,
    output wire        supplement_mode_pin_enable,
    output wire        conservative_supplement_enable,
    output wire        input_current_optimizer_enable,
    output wire        inductor_clamp_enable,
    output reg  [4:0]  inductor_clamp_amps,
    output wire        reverse_output_range_select,
    output wire        power_monitor_reverse_select
);

    wire        rst_n;
    reg  [15:0] charger_option_three_control;
    reg  [15:0] next_control;
    reg         meas_state;
    reg         next_meas_state;
    wire        wr_low;
    wire        wr_high;
    wire        restore_req;
    wire        remeasure_req;
    wire        meas_finish;
    reg  [7:0]  next_rd_data;
    reg         next_rd_hit;

    cocr_reset_sync u_reset_sync (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .sync_reset_n (rst_n)
    );

    // Byte lane decodes; a strobe to any other address is ignored here.
    assign wr_low        = reg_wr_en && (reg_addr == `COCR_ADDR_LOW);
    assign wr_high       = reg_wr_en && (reg_addr == `COCR_ADDR_HIGH);
    assign restore_req   = wr_high && reg_wr_data[`COCR_BIT_RESTORE - `COCR_HIGH_BYTE_BASE];
    assign remeasure_req = wr_high && reg_wr_data[`COCR_BIT_REMEASURE - `COCR_HIGH_BYTE_BASE];

    // Remeasure sequencer: a new request in the done cycle wins and restarts it.
    always @* begin
        next_meas_state = meas_state;
        case (meas_state)
            `COCR_ST_IDLE: begin
                if (remeasure_req) begin
                    next_meas_state = `COCR_ST_MEASURE;
                end
            end
            `COCR_ST_MEASURE: begin
                if (remeasure_done && !remeasure_req) begin
                    next_meas_state = `COCR_ST_IDLE;
                end
            end
            default: begin
                next_meas_state = `COCR_ST_IDLE;
            end
        endcase
    end

    // Reserved bits are stored as written; the host keeps them zero.
    always @* begin
        next_control = charger_option_three_control;
        if (restore_req) begin
            next_control = `COCR_RESET_VALUE;
        end else begin
            if (wr_low) begin
                next_control[7:0] = reg_wr_data;
            end
            if (wr_high) begin
                next_control[15:8] = reg_wr_data;
            end
        end
        // Restore is an action, not a state; the bit never reads back as one.
        next_control[`COCR_BIT_RESTORE] = 1'b0;
        // The remeasure bit mirrors the sequencer, so a host that writes zero to it
        // mid-measurement cannot cancel a pause that the converter relies on.
        next_control[`COCR_BIT_REMEASURE] = next_meas_state;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_option_three_control  <= `COCR_RESET_VALUE;
            meas_state                    <= `COCR_ST_IDLE;
            restore_defaults_pulse        <= 1'b0;
            minimum_system_voltage_load   <= `COCR_MINIMUM_SYSTEM_VOLTAGE_DEFAULT;
            charge_voltage_default_select <= `COCR_CELL_SELECT_RESET;
            remeasure_start_pulse         <= 1'b0;
            converter_restart_pulse       <= 1'b0;
        end else begin
            charger_option_three_control <= next_control;
            meas_state                   <= next_meas_state;
            restore_defaults_pulse       <= restore_req;
            remeasure_start_pulse        <= remeasure_req;
            converter_restart_pulse      <= meas_finish;
            if (restore_req) begin
                minimum_system_voltage_load   <= `COCR_MINIMUM_SYSTEM_VOLTAGE_DEFAULT;
                charge_voltage_default_select <= cell_count_pin;
            end
        end
    end

    // The restart pulse marks the one cycle in which a measurement ends.
    // A new request in that cycle keeps the sequencer busy, so no restart is sent.
    assign meas_finish = (meas_state == `COCR_ST_MEASURE) &&
                         (next_meas_state == `COCR_ST_IDLE);

    // Read decode: only the two byte lanes of this register answer.
    always @* begin
        next_rd_hit  = 1'b0;
        next_rd_data = `COCR_READ_IDLE;
        if (reg_rd_en) begin
            case (reg_addr)
                `COCR_ADDR_LOW: begin
                    next_rd_hit  = 1'b1;
                    next_rd_data = charger_option_three_control[7:0];
                end
                `COCR_ADDR_HIGH: begin
                    next_rd_hit  = 1'b1;
                    next_rd_data = charger_option_three_control[15:8];
                end
                default: begin
                    next_rd_hit  = 1'b0;
                    next_rd_data = `COCR_READ_IDLE;
                end
            endcase
        end
    end

    // Read data is registered; other addresses belong to other registers.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= `COCR_READ_IDLE;
            reg_rd_hit  <= 1'b0;
        end else begin
            reg_rd_data <= next_rd_data;
            reg_rd_hit  <= next_rd_hit;
        end
    end

    // Clamp level decode.
    always @* begin
        case (charger_option_three_control[`COCR_CLAMP_MSB:`COCR_CLAMP_LSB])
            `COCR_CLAMP_6A_CODE:  inductor_clamp_amps = `COCR_CLAMP_6A;
            `COCR_CLAMP_10A_CODE: inductor_clamp_amps = `COCR_CLAMP_10A;
            `COCR_CLAMP_15A_CODE: inductor_clamp_amps = `COCR_CLAMP_15A;
            default:              inductor_clamp_amps = `COCR_CLAMP_NONE;
        endcase
    end

    assign inductor_clamp_enable = charger_option_three_control[`COCR_CLAMP_MSB:`COCR_CLAMP_LSB]
                                   != `COCR_CLAMP_OFF_CODE;

    assign converter_pause = meas_state;

    assign high_impedance_state_enable  = charger_option_three_control[`COCR_BIT_HIZ];
    // In idle the regulator survives only while the input stays above lockout.
    assign internal_regulator_output_on = !high_impedance_state_enable ||
                                          input_above_uvlo;
    assign system_from_battery          = high_impedance_state_enable;
    assign battery_switch_off_in_idle   = high_impedance_state_enable &&
                                          charger_option_three_control[`COCR_BIT_BATT_OFF_IDLE];

    // The shared pin serves only one function at a time, chosen by the select bit.
    assign reverse_supply_active = charger_option_three_control[`COCR_BIT_REVERSE] &&
                                   charger_option_three_control[`COCR_BIT_PIN_SELECT] &&
                                   shared_pin_level;
    assign supplement_mode_pin_enable = !charger_option_three_control[`COCR_BIT_PIN_SELECT] &&
                                        shared_pin_level;

    assign conservative_supplement_enable = charger_option_three_control[`COCR_BIT_CONS_SUPP];
    assign input_current_optimizer_enable = charger_option_three_control[`COCR_BIT_OPTIMIZER];
    assign reverse_output_range_select    = charger_option_three_control[`COCR_BIT_RANGE_LOW];
    assign power_monitor_reverse_select   = charger_option_three_control[`COCR_BIT_PMON_SELECT];

endmodule

`default_nettype wire

// [dv/cocr_converter_model.sv]
// Converter side model that answers input limit remeasure requests.
// Assumes start requests arrive as one-cycle pulses on core_clk.
`timescale 1ns/100ps
`default_nettype none
module cocr_converter_model #(parameter int DELAY = 12) (
    input  wire logic core_clk,
    input  wire logic remeasure_start_pulse,
    output var  logic remeasure_done
);
    int count = 0;
    initial remeasure_done = 1'b0;
    // A measurement takes several cycles so the pause is seen by the host.
    always @(posedge core_clk) begin
        remeasure_done <= count == 1;
        if (remeasure_start_pulse) count <= DELAY;
        else if (count > 0) count <= count - 1;
    end
endmodule
`default_nettype wire

// [dv/cocr_control_chk.sv]
// Timing checks on the control register block ports.
// Assumes it is bound to cocr_control_reg.
`timescale 1ns/100ps
`default_nettype none
module cocr_control_chk (
    input wire       core_clk, reset_n, reg_wr_en, reg_rd_en, reg_rd_hit,
    input wire [7:0] reg_addr, reg_wr_data, reg_rd_data,
    input wire [1:0] cell_count_pin, charge_voltage_default_select,
    input wire       shared_pin_level, remeasure_done, restore_defaults_pulse,
    input wire       remeasure_start_pulse, converter_pause, converter_restart_pulse,
    input wire       high_impedance_state_enable, system_from_battery,
    input wire       reverse_supply_active, supplement_mode_pin_enable,
    input wire       inductor_clamp_enable,
    input wire [4:0] inductor_clamp_amps
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire hi_wr = reg_wr_en && reg_addr == 8'h35;
    wire restore_now = hi_wr && reg_wr_data[6];
    sequence restore_wr; restore_now; endsequence
    sequence one_pulse; restore_defaults_pulse ##1 !restore_defaults_pulse; endsequence
    restore_pulse_a: assert property (restore_wr ##1 !restore_now |-> one_pulse)
        else $error("restore pulse wrong");
    hiz_write_a: assert property (hi_wr && !reg_wr_data[6] |=>
        high_impedance_state_enable == $past(reg_wr_data[7])) else $error("hiz bit wrong");
    cell_capture_a: assert property (restore_wr |=>
        charge_voltage_default_select == $past(cell_count_pin)) else $error("cell select wrong");
    measure_start_a: assert property (hi_wr && reg_wr_data[5] |=>
        remeasure_start_pulse && converter_pause) else $error("remeasure start wrong");
    measure_end_a: assert property (converter_pause && remeasure_done && !hi_wr |=>
        converter_restart_pulse && !converter_pause) else $error("remeasure end wrong");
    read_idle_a: assert property (!(reg_rd_en && reg_addr[7:1] == 7'h1A) |=>
        !reg_rd_hit && reg_rd_data == 8'h00) else $error("read idle wrong");
    pin_gate_a: assert property (!shared_pin_level |->
        !reverse_supply_active && !supplement_mode_pin_enable) else $error("pin gate wrong");
    hiz_battery_a: assert property (system_from_battery == high_impedance_state_enable)
        else $error("battery supply wrong");
    clamp_code_a: assert property (inductor_clamp_enable ==
        (inductor_clamp_amps inside {5'h06, 5'h0A, 5'h0F})) else $error("clamp wrong");
endmodule
bind cocr_control_reg cocr_control_chk chk_u (.core_clk, .reset_n, .reg_wr_en, .reg_rd_en,
    .reg_rd_hit, .reg_addr, .reg_wr_data, .reg_rd_data, .cell_count_pin,
    .charge_voltage_default_select, .shared_pin_level, .remeasure_done,
    .restore_defaults_pulse, .remeasure_start_pulse, .converter_pause,
    .converter_restart_pulse, .high_impedance_state_enable, .system_from_battery,
    .reverse_supply_active, .supplement_mode_pin_enable, .inductor_clamp_enable,
    .inductor_clamp_amps);
`default_nettype wire

// [dv/charger_option3_control_reg_bench.sv]
// Self-checking bench for the charger option three control register.
// Assumes the converter model answers every remeasure request.
`timescale 1ns/100ps
`default_nettype none
module charger_option3_control_reg_bench;
    logic core_clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic shared_pin_level = 1'b0, input_above_uvlo = 1'b0, remeasure_done;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
    logic [1:0] cell_count_pin = 2'h0, charge_voltage_default_select;
    logic [15:0] minimum_system_voltage_load;
    logic [4:0] inductor_clamp_amps;
    logic reg_rd_hit, restore_defaults_pulse, remeasure_start_pulse, converter_pause;
    logic converter_restart_pulse, high_impedance_state_enable, internal_regulator_output_on;
    logic system_from_battery, battery_switch_off_in_idle, reverse_supply_active;
    logic supplement_mode_pin_enable, conservative_supplement_enable, inductor_clamp_enable;
    logic input_current_optimizer_enable, reverse_output_range_select;
    logic power_monitor_reverse_select;
    int bad_count = 0, checked = 0;
    cocr_control_reg dut_u (.core_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data, .reg_rd_hit, .shared_pin_level, .input_above_uvlo,
        .cell_count_pin, .remeasure_done, .restore_defaults_pulse,
        .minimum_system_voltage_load, .charge_voltage_default_select,
        .remeasure_start_pulse, .converter_pause, .converter_restart_pulse,
        .high_impedance_state_enable, .internal_regulator_output_on, .system_from_battery,
        .battery_switch_off_in_idle, .reverse_supply_active, .supplement_mode_pin_enable,
        .conservative_supplement_enable, .input_current_optimizer_enable,
        .inductor_clamp_enable, .inductor_clamp_amps, .reverse_output_range_select,
        .power_monitor_reverse_select);
    cocr_converter_model conv_u (.core_clk, .remeasure_start_pulse, .remeasure_done);
    initial forever #4 core_clk = ~core_clk;
    task automatic wrap_up();
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Each access starts one edge after the previous one ended, so no strobe is
    // lowered and raised again in the same time step.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        tick();
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick();
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        tick();
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick();
        reg_rd_en = 1'b0;
        chk("read data", 16'(exp), 16'(reg_rd_data));
        chk("read hit", 16'(a[7:1] == 7'h1A), 16'(reg_rd_hit));
    endtask
    task automatic t_power_on();
        rd(8'h34, 8'h30);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h00);
        chk("vsys", 16'h0E00, minimum_system_voltage_load);
        chk("clamp", 16'h000F, 16'(inductor_clamp_amps));
        chk("optimizer", 16'h0000, 16'(input_current_optimizer_enable));
    endtask
    task automatic t_controls();
        logic [4:0] amps [4] = '{5'h06, 5'h0A, 5'h0F, 5'h00};
        wr(8'h35, 8'h88);
        chk("hiz", 16'h0001, 16'(high_impedance_state_enable));
        chk("regulator", 16'h0000, 16'(internal_regulator_output_on));
        chk("optimizer", 16'h0001, 16'(input_current_optimizer_enable));
        input_above_uvlo = 1'b1;
        #1 chk("regulator", 16'h0001, 16'(internal_regulator_output_on));
        wr(8'h35, 8'h10);
        shared_pin_level = 1'b1;
        #1 chk("reverse", 16'h0001, 16'(reverse_supply_active));
        wr(8'h34, 8'h10);
        chk("reverse", 16'h0000, 16'(reverse_supply_active));
        chk("supplement", 16'h0001, 16'(supplement_mode_pin_enable));
        for (int i = 0; i < 4; i++) begin
            wr(8'h34, 8'(i << 3) | 8'h04);
            chk("clamp", 16'(amps[i]), 16'(inductor_clamp_amps));
            chk("range", 16'h0001, 16'(reverse_output_range_select));
            chk("clamp on", 16'(i != 3), 16'(inductor_clamp_enable));
        end
        wr(8'h35, 8'h80);
        chk("battery", 16'h0001, 16'(system_from_battery));
        wr(8'h34, 8'h43);
        chk("clamp", 16'h0006, 16'(inductor_clamp_amps));
        chk("range", 16'h0000, 16'(reverse_output_range_select));
        chk("conservative", 16'h0001, 16'(conservative_supplement_enable));
        chk("battery off", 16'h0001, 16'(battery_switch_off_in_idle));
        chk("power monitor", 16'h0001, 16'(power_monitor_reverse_select));
    endtask
    task automatic t_restore();
        cell_count_pin = 2'h2;
        wr(8'h35, 8'h58);
        chk("restore", 16'h0001, 16'(restore_defaults_pulse));
        chk("cells", 16'h0002, 16'(charge_voltage_default_select));
        chk("vsys", 16'h0E00, minimum_system_voltage_load);
        rd(8'h35, 8'h00);
        rd(8'h34, 8'h30);
    endtask
    task automatic t_remeasure();
        int n;
        wr(8'h35, 8'h20);
        chk("pause", 16'h0001, 16'(converter_pause));
        chk("start", 16'h0001, 16'(remeasure_start_pulse));
        for (n = 0; n < 40 && converter_restart_pulse !== 1'b1; n++) tick();
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
        chk("pause", 16'h0000, 16'(converter_pause));
        rd(8'h35, 8'h00);
    endtask
    task automatic t_reset_again();
        wr(8'h35, 8'h18);
        chk("optimizer", 16'h0001, 16'(input_current_optimizer_enable));
        chk("reverse", 16'h0001, 16'(reverse_supply_active));
        reset_n = 1'b0;
        tick(2);
        chk("optimizer", 16'h0000, 16'(input_current_optimizer_enable));
        chk("reverse", 16'h0000, 16'(reverse_supply_active));
        reset_n = 1'b1;
        tick(3);
        rd(8'h35, 8'h00);
        rd(8'h34, 8'h30);
    endtask
    initial begin
        tick(20);
        reset_n = 1'b1;
        tick(3);
        t_power_on();
        t_controls();
        t_restore();
        t_remeasure();
        t_reset_again();
        wrap_up();
    end
endmodule
`default_nettype wire
